// File: core/fprc_pkg.sv
// Shared constants and types for the flash read and program controller.
// Assumes a 100 MHz core clock and a 32-bit AHB-Lite register bus.
`default_nettype none

package fprc_pkg;

	// Clock and programming times.
	localparam int CLK_PERIOD_NS = 10;
	localparam int BYTE_PROG_US = 66;
	localparam int ROW_BYTE_PROG_US = 41;
	localparam int ROW_LIMIT_MS = 31;
	// Least times round up, the longest row time rounds down.
	localparam int BYTE_PROG_CYCLES =
		(BYTE_PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ROW_BYTE_PROG_CYCLES =
		(ROW_BYTE_PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ROW_LIMIT_CYCLES = ROW_LIMIT_MS * 1000000 / CLK_PERIOD_NS;

	// Array geometry: 128 pages of 8 rows of 256 bytes.
	localparam int COL_W = 8;
	localparam int ROW_W = 3;
	localparam int PAGE_W = 7;
	localparam int ADDR_W = PAGE_W + ROW_W + COL_W;
	localparam int BLK_W = 3;
	localparam int NUM_BLOCKS = 8;
	localparam logic [COL_W-1:0] COL_LAST = 8'hff;
	localparam logic [ROW_W-1:0] ROW_LAST = 3'h7;
	localparam logic [COL_W-1:0] COL_ONE = 8'h01;
	localparam logic [ROW_W-1:0] ROW_ONE = 3'h1;
	localparam logic [PAGE_W-1:0] PAGE_ONE = 7'h01;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// Timer width covers the row limit count.
	localparam int TMR_W = 22;
	localparam logic [TMR_W-1:0] TMR_ONE = 22'h000001;

	// Register word indices; byte address is four times the index.
	localparam int IDX_W = 10;
	localparam logic [IDX_W-1:0] IDX_DATA = 10'h0f6;
	localparam logic [IDX_W-1:0] IDX_CTRL = 10'h0f8;
	localparam logic [IDX_W-1:0] IDX_PGCTL = 10'h0f9;
	localparam logic [IDX_W-1:0] IDX_PROT = 10'h0fa;
	localparam logic [IDX_W-1:0] IDX_STAT = 10'h0fb;
	localparam logic [IDX_W-1:0] IDX_PAGE = 10'h0fc;
	localparam logic [IDX_W-1:0] IDX_ROW = 10'h0fd;
	localparam logic [IDX_W-1:0] IDX_COL = 10'h0fe;

	// Field positions and reset values.
	localparam int CTRL_WAIT_W = 3;
	localparam int CTRL_MEM_EN_BIT = 3;
	localparam int PAGE_INFO_BIT = 7;
	localparam int PGCTL_ROW_BIT = 0;
	localparam int STAT_ROW_DONE_BIT = 0;
	localparam int STAT_TIMEOUT_BIT = 1;
	localparam int STAT_PROT_ERR_BIT = 2;
	localparam int STAT_BUSY_BIT = 3;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] PROT_RST = 8'h00;
	localparam logic [7:0] PAGE_RST = 8'h00;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [0:0] {RD_IDLE, RD_WAIT} fprc_rd_state_t;
	typedef enum logic [1:0] {PG_IDLE, PG_BYTE, PG_HOLD} fprc_pg_state_t;

endpackage

`default_nettype wire

// File: core/fprc_prog_timer.sv
// Down counter that flags expiry a loaded number of cycles after start.
// Assumes a nonzero load; a start while running restarts the count.
`timescale 1ns/10ps
`default_nettype none

module fprc_prog_timer (
	input wire logic clk, // core clock
	input wire logic rst, // asynchronous reset, active high
	fprc_timer_if.timer tmr // start, load and expiry
);

	logic [fprc_pkg::TMR_W-1:0] count;
	logic [fprc_pkg::TMR_W-1:0] next_count;
	logic run;
	logic next_run;

	always_comb begin
		next_count = count;
		next_run = run;
		if (tmr.start) begin
			next_count = tmr.load;
			next_run = 1'b1;
		end else if (run) begin
			if (count == fprc_pkg::TMR_ONE) begin
				next_run = 1'b0;
			end else begin
				next_count = count - fprc_pkg::TMR_ONE;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= '0;
			run <= 1'b0;
		end else begin
			count <= next_count;
			run <= next_run;
		end
	end

	assign tmr.expired = run && (count == fprc_pkg::TMR_ONE);

endmodule

`default_nettype wire

// File: core/fprc_timer_if.sv
// Start and expiry signals between the controller and a programming timer.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps
`default_nettype none

interface fprc_timer_if;
	logic start;
	logic [fprc_pkg::TMR_W-1:0] load;
	logic expired;
	modport owner (output start, output load, input expired);
	modport timer (input start, input load, output expired);
endinterface

`default_nettype wire

// File: core/fprc_top.sv
// Flash read and program controller: AHB-Lite registers, CPU memory port,
// indirect data port and self-timed byte and row programming.
// Assumes an array with an asynchronous read port and a program port.
// Summary of operation
// - Array is 128 pages of 8 rows of 256 bytes, page/row/column addressed.
// - An information page of two rows, 512 bytes, is separately selectable.
// - Eight 32 KB protection blocks; protected blocks reject every program.
// - The lowest block is protected by the write-protect pin, not a register.
// - CPU memory reads and writes are translated into array accesses.
// - The array is also an indirect byte store behind the data register.
// - Reads of other rows continue while a row is being programmed.
// - Memory reads reach the main array only; info page via data register.
// - Every array read gets automatic wait states.
// - A data register read returns the byte at the page/row/column address.
// - Each data register access advances the stored address by one.
// - A single-byte data write stalls the CPU until programming finishes.
// - Row programming only by data writes while row-burst enable is set.
// - Row mode holds high voltage until column 255; each byte stalls.
// - Each row-mode byte takes its documented programming time.
// - Row time-out aborts row programming and sets an error flag.
// - Memory writes program exactly one byte and never use row mode.
//
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module fprc_top #(
	parameter int BYTE_PROG_CYCLES = fprc_pkg::BYTE_PROG_CYCLES,
	parameter int ROW_BYTE_PROG_CYCLES = fprc_pkg::ROW_BYTE_PROG_CYCLES,
	parameter int ROW_LIMIT_CYCLES = fprc_pkg::ROW_LIMIT_CYCLES
) (
	input wire logic core_clk, // core clock
	input wire logic rst, // asynchronous reset, active high
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write transfer
	input wire logic [2:0] hsize, // transfer size, words only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // always OKAY
	output logic [31:0] hrdata, // read data
	input wire logic memReq, // CPU memory cycle, held until memDone
	input wire logic memWrite, // memory cycle is a write
	input wire logic [fprc_pkg::ADDR_W-1:0] memAddr, // flash byte offset
	input wire logic [7:0] memWdata, // memory write data
	output logic [7:0] memRdata, // memory read data
	output logic memDone, // memory cycle finished
	input wire logic wpPinN, // write-protect pin, low protects block 0
	output logic arrRdEn, // array read enable
	output logic [fprc_pkg::ADDR_W-1:0] arrRdAddr, // array read address
	output logic arrRdInfo, // read targets the information page
	input wire logic [7:0] arrRdData, // array read data
	output logic arrPgStrobe, // array byte programming in progress
	output logic [fprc_pkg::ADDR_W-1:0] arrPgAddr, // program address
	output logic arrPgInfo, // program targets the information page
	output logic [7:0] arrPgData, // program data
	output logic arrHighVolt // programming high voltage
);

	localparam logic [fprc_pkg::TMR_W-1:0] BYTE_LOAD =
		BYTE_PROG_CYCLES[fprc_pkg::TMR_W-1:0];
	localparam logic [fprc_pkg::TMR_W-1:0] ROW_BYTE_LOAD =
		ROW_BYTE_PROG_CYCLES[fprc_pkg::TMR_W-1:0];
	localparam logic [fprc_pkg::TMR_W-1:0] ROW_LIMIT_LOAD =
		ROW_LIMIT_CYCLES[fprc_pkg::TMR_W-1:0];
	localparam int AW = fprc_pkg::ADDR_W;
	localparam int CW = fprc_pkg::COL_W;

	fprc_pkg::fprc_rd_state_t rdState, next_rdState;
	fprc_pkg::fprc_pg_state_t pgState, next_pgState;
	logic aValid, next_aValid, aWrite, next_aWrite;
	logic [fprc_pkg::IDX_W-1:0] aIdx, next_aIdx;
	logic ioStarted, next_ioStarted, ioAck, next_ioAck;
	logic [31:0] hrdataReg, next_hrdataReg;
	logic [7:0] pageReg, next_pageReg, ctrlReg, next_ctrlReg;
	logic [7:0] protReg, next_protReg, colReg, next_colReg;
	logic [fprc_pkg::ROW_W-1:0] rowReg, next_rowReg;
	logic pgctlRow, next_pgctlRow;
	logic rowDone, next_rowDone, rowTimeout, next_rowTimeout;
	logic protErr, next_protErr;
	logic [fprc_pkg::CTRL_WAIT_W-1:0] rdCnt, next_rdCnt;
	logic rdForIo, next_rdForIo, rdInfo, next_rdInfo;
	logic [AW-1:0] rdAddr, next_rdAddr, pgAddr, next_pgAddr;
	logic [7:0] memRdataReg, next_memRdataReg, pgData, next_pgData;
	logic memDoneReg, next_memDoneReg;
	logic pgInfo, next_pgInfo, pgFromIo, next_pgFromIo;
	logic rowMode, next_rowMode, highVolt, next_highVolt;
	logic wpMeta, wpSync;
	logic byteStart, rowStart;
	logic [fprc_pkg::TMR_W-1:0] byteLoad;
	logic [7:0] rdMux;
	logic [AW-1:0] curAddr;
	logic [fprc_pkg::NUM_BLOCKS-1:0] blockProt;
	logic curInfo, aIsData, memEn, pgActive, addrPhase;
	logic ioRdReq, ioWrReq, memRdReq, memWrReq;
	logic ioProt, memProt, ioRowHit, memRowHit;

	fprc_timer_if byteTmr ();
	fprc_timer_if rowTmr ();

	fprc_prog_timer uByteTimer (
		.clk(core_clk),
		.rst(rst),
		.tmr(byteTmr.timer)
	);

	fprc_prog_timer uRowTimer (
		.clk(core_clk),
		.rst(rst),
		.tmr(rowTmr.timer)
	);

	assign byteTmr.start = byteStart;
	assign byteTmr.load = byteLoad;
	assign rowTmr.start = rowStart;
	assign rowTmr.load = ROW_LIMIT_LOAD;

	assign curAddr = {pageReg[fprc_pkg::PAGE_W-1:0], rowReg, colReg};
	assign curInfo = pageReg[fprc_pkg::PAGE_INFO_BIT];
	assign blockProt = {protReg[fprc_pkg::NUM_BLOCKS-1:1], ~wpSync};
	assign ioProt = !curInfo && blockProt[curAddr[AW-1 -: fprc_pkg::BLK_W]];
	assign memProt = blockProt[memAddr[AW-1 -: fprc_pkg::BLK_W]];
	assign aIsData = (aIdx == fprc_pkg::IDX_DATA);
	assign memEn = ctrlReg[fprc_pkg::CTRL_MEM_EN_BIT];
	assign pgActive = (pgState != fprc_pkg::PG_IDLE);
	assign addrPhase = hsel && hready && (htrans == fprc_pkg::HTRANS_NONSEQ);
	assign ioRdReq = aValid && aIsData && !aWrite && !ioStarted;
	assign ioWrReq = aValid && aIsData && aWrite && !ioStarted;
	// The done pulse masks the request the CPU has not yet dropped.
	assign memRdReq = memReq && !memWrite && !memDoneReg;
	assign memWrReq = memReq && memWrite && !memDoneReg;
	// only the row under programming blocks reads
	assign ioRowHit = pgActive && (curInfo == pgInfo) &&
		(curAddr[AW-1:CW] == pgAddr[AW-1:CW]);
	assign memRowHit = pgActive && !pgInfo &&
		(memAddr[AW-1:CW] == pgAddr[AW-1:CW]);

	always_comb begin
		next_rdState = rdState;
		next_pgState = pgState;
		next_aValid = aValid;
		next_aWrite = aWrite;
		next_aIdx = aIdx;
		next_ioStarted = ioStarted;
		next_ioAck = ioAck;
		next_hrdataReg = hrdataReg;
		next_pageReg = pageReg;
		next_rowReg = rowReg;
		next_colReg = colReg;
		next_ctrlReg = ctrlReg;
		next_protReg = protReg;
		next_pgctlRow = pgctlRow;
		next_rowDone = rowDone;
		next_rowTimeout = rowTimeout;
		next_protErr = protErr;
		next_rdCnt = rdCnt;
		next_rdForIo = rdForIo;
		next_rdInfo = rdInfo;
		next_rdAddr = rdAddr;
		next_memRdataReg = memRdataReg;
		next_memDoneReg = 1'b0;
		next_pgAddr = pgAddr;
		next_pgInfo = pgInfo;
		next_pgData = pgData;
		next_pgFromIo = pgFromIo;
		next_rowMode = rowMode;
		next_highVolt = highVolt;
		byteStart = 1'b0;
		byteLoad = BYTE_LOAD;
		rowStart = 1'b0;

		if (aValid && aIsData && ioAck) begin
			next_aValid = 1'b0;
			next_ioAck = 1'b0;
			next_ioStarted = 1'b0;
			next_colReg = colReg + fprc_pkg::COL_ONE;
			if (colReg == fprc_pkg::COL_LAST) begin
				next_rowReg = rowReg + fprc_pkg::ROW_ONE;
				if (rowReg == fprc_pkg::ROW_LAST) begin
					next_pageReg[fprc_pkg::PAGE_W-1:0] =
						pageReg[fprc_pkg::PAGE_W-1:0] + fprc_pkg::PAGE_ONE;
				end
			end
		end else if (aValid && !aIsData) begin
			next_aValid = 1'b0;
			if (aWrite) begin
				case (aIdx)
					fprc_pkg::IDX_PAGE: next_pageReg = hwdata[7:0];
					fprc_pkg::IDX_ROW: next_rowReg = hwdata[fprc_pkg::ROW_W-1:0];
					fprc_pkg::IDX_COL: next_colReg = hwdata[7:0];
					fprc_pkg::IDX_CTRL: next_ctrlReg = hwdata[7:0];
					fprc_pkg::IDX_PROT: next_protReg = hwdata[7:0];
					fprc_pkg::IDX_PGCTL: begin
						next_pgctlRow = hwdata[fprc_pkg::PGCTL_ROW_BIT];
					end
					fprc_pkg::IDX_STAT: begin
						// Ones clear; engine sets below still win.
						next_rowDone = rowDone &
							~hwdata[fprc_pkg::STAT_ROW_DONE_BIT];
						next_rowTimeout = rowTimeout &
							~hwdata[fprc_pkg::STAT_TIMEOUT_BIT];
						next_protErr = protErr &
							~hwdata[fprc_pkg::STAT_PROT_ERR_BIT];
					end
					default: ;
				endcase
			end
		end

		unique case (rdState)
			fprc_pkg::RD_IDLE: begin
				// data register read at stored address
				if (ioRdReq && !ioRowHit) begin
					next_ioStarted = 1'b1;
					next_rdForIo = 1'b1;
					next_rdAddr = curAddr;
					next_rdInfo = curInfo;
					next_rdCnt = ctrlReg[fprc_pkg::CTRL_WAIT_W-1:0];
					next_rdState = fprc_pkg::RD_WAIT;
				end else if (memRdReq && !memEn) begin
					next_memRdataReg = fprc_pkg::ERASED_BYTE;
					next_memDoneReg = 1'b1;
				// memory reads see the main array only
				end else if (memRdReq && !memRowHit) begin
					next_rdForIo = 1'b0;
					next_rdAddr = memAddr;
					next_rdInfo = 1'b0;
					next_rdCnt = ctrlReg[fprc_pkg::CTRL_WAIT_W-1:0];
					next_rdState = fprc_pkg::RD_WAIT;
				end
			end
			fprc_pkg::RD_WAIT: begin
				if (rdCnt == '0) begin
					next_rdState = fprc_pkg::RD_IDLE;
					if (rdForIo) begin
						next_hrdataReg = {24'h000000, arrRdData};
						next_ioAck = 1'b1;
					end else begin
						next_memRdataReg = arrRdData;
						next_memDoneReg = 1'b1;
					end
				end else begin
					next_rdCnt = rdCnt - 3'h1;
				end
			end
		endcase

		unique case (pgState)
			fprc_pkg::PG_IDLE: begin
				if (ioWrReq) begin
					next_ioStarted = 1'b1;
					if (ioProt) begin
						next_protErr = 1'b1;
						next_ioAck = 1'b1;
					end else begin
						// row mode only from data writes
						next_rowMode = pgctlRow;
						next_pgFromIo = 1'b1;
						next_pgAddr = curAddr;
						next_pgInfo = curInfo;
						next_pgData = hwdata[7:0];
						next_highVolt = 1'b1;
						byteStart = 1'b1;
						byteLoad = pgctlRow ? ROW_BYTE_LOAD : BYTE_LOAD;
						rowStart = pgctlRow;
						next_pgState = fprc_pkg::PG_BYTE;
					end
				end else if (memWrReq) begin
					if (!memEn || memProt) begin
						next_protErr = next_protErr || memProt;
						next_memDoneReg = 1'b1;
					end else begin
						// memory write is one plain byte
						next_rowMode = 1'b0;
						next_pgFromIo = 1'b0;
						next_pgAddr = memAddr;
						next_pgInfo = 1'b0;
						next_pgData = memWdata;
						next_highVolt = 1'b1;
						byteStart = 1'b1;
						next_pgState = fprc_pkg::PG_BYTE;
					end
				end
			end
			fprc_pkg::PG_BYTE: begin
				if (rowMode && rowTmr.expired) begin
					next_highVolt = 1'b0;
					next_pgctlRow = 1'b0;
					next_rowTimeout = 1'b1;
					next_ioAck = 1'b1;
					next_pgState = fprc_pkg::PG_IDLE;
				end else if (byteTmr.expired && rowMode) begin
					next_ioAck = 1'b1;
					if (pgAddr[CW-1:0] == fprc_pkg::COL_LAST) begin
						next_highVolt = 1'b0;
						next_pgctlRow = 1'b0;
						next_rowDone = 1'b1;
						next_pgState = fprc_pkg::PG_IDLE;
					end else begin
						next_pgState = fprc_pkg::PG_HOLD;
					end
				// stall released when the byte is done
				end else if (byteTmr.expired) begin
					next_highVolt = 1'b0;
					next_ioAck = next_ioAck || pgFromIo;
					next_memDoneReg = next_memDoneReg || !pgFromIo;
					next_pgState = fprc_pkg::PG_IDLE;
				end
			end
			fprc_pkg::PG_HOLD: begin
				// Memory writes wait here rather than joining the row.
				if (rowTmr.expired) begin
					next_highVolt = 1'b0;
					next_pgctlRow = 1'b0;
					next_rowTimeout = 1'b1;
					next_pgState = fprc_pkg::PG_IDLE;
				end else if (!pgctlRow) begin
					next_highVolt = 1'b0;
					next_pgState = fprc_pkg::PG_IDLE;
				end else if (ioWrReq) begin
					next_ioStarted = 1'b1;
					if (ioProt) begin
						next_protErr = 1'b1;
						next_ioAck = 1'b1;
					end else begin
						next_pgAddr = curAddr;
						next_pgInfo = curInfo;
						next_pgData = hwdata[7:0];
						byteStart = 1'b1;
						byteLoad = ROW_BYTE_LOAD;
						next_pgState = fprc_pkg::PG_BYTE;
					end
				end
			end
		endcase

		// Read value built from next state so a write is seen at once.
		case (haddr[fprc_pkg::IDX_W+1:2])
			fprc_pkg::IDX_PAGE: rdMux = next_pageReg;
			fprc_pkg::IDX_ROW: rdMux = {5'h00, next_rowReg};
			fprc_pkg::IDX_COL: rdMux = next_colReg;
			fprc_pkg::IDX_CTRL: rdMux = next_ctrlReg;
			fprc_pkg::IDX_PGCTL: rdMux = {7'h00, next_pgctlRow};
			fprc_pkg::IDX_PROT: rdMux = {next_protReg[7:1], ~wpSync};
			fprc_pkg::IDX_STAT: begin
				rdMux = {4'h0, next_pgState != fprc_pkg::PG_IDLE,
					next_protErr, next_rowTimeout, next_rowDone};
			end
			default: rdMux = 8'h00;
		endcase

		// address phase of every NONSEQ access over the register bus
		if (addrPhase) begin
			next_aValid = 1'b1;
			next_aWrite = hwrite;
			next_aIdx = haddr[fprc_pkg::IDX_W+1:2];
			if (!hwrite && haddr[fprc_pkg::IDX_W+1:2] != fprc_pkg::IDX_DATA) begin
				next_hrdataReg = {24'h000000, rdMux};
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdState <= fprc_pkg::RD_IDLE;
			pgState <= fprc_pkg::PG_IDLE;
			aValid <= 1'b0;
			aWrite <= 1'b0;
			aIdx <= '0;
			ioStarted <= 1'b0;
			ioAck <= 1'b0;
			hrdataReg <= '0;
			pageReg <= fprc_pkg::PAGE_RST;
			rowReg <= '0;
			colReg <= '0;
			ctrlReg <= fprc_pkg::CTRL_RST;
			protReg <= fprc_pkg::PROT_RST;
			pgctlRow <= 1'b0;
			rowDone <= 1'b0;
			rowTimeout <= 1'b0;
			protErr <= 1'b0;
			rdCnt <= '0;
			rdForIo <= 1'b0;
			rdInfo <= 1'b0;
			rdAddr <= '0;
			memRdataReg <= '0;
			memDoneReg <= 1'b0;
			pgAddr <= '0;
			pgInfo <= 1'b0;
			pgData <= '0;
			pgFromIo <= 1'b0;
			rowMode <= 1'b0;
			highVolt <= 1'b0;
			wpMeta <= 1'b1;
			wpSync <= 1'b1;
		end else begin
			rdState <= next_rdState;
			pgState <= next_pgState;
			aValid <= next_aValid;
			aWrite <= next_aWrite;
			aIdx <= next_aIdx;
			ioStarted <= next_ioStarted;
			ioAck <= next_ioAck;
			hrdataReg <= next_hrdataReg;
			pageReg <= next_pageReg;
			rowReg <= next_rowReg;
			colReg <= next_colReg;
			ctrlReg <= next_ctrlReg;
			protReg <= next_protReg;
			pgctlRow <= next_pgctlRow;
			rowDone <= next_rowDone;
			rowTimeout <= next_rowTimeout;
			protErr <= next_protErr;
			rdCnt <= next_rdCnt;
			rdForIo <= next_rdForIo;
			rdInfo <= next_rdInfo;
			rdAddr <= next_rdAddr;
			memRdataReg <= next_memRdataReg;
			memDoneReg <= next_memDoneReg;
			pgAddr <= next_pgAddr;
			pgInfo <= next_pgInfo;
			pgData <= next_pgData;
			pgFromIo <= next_pgFromIo;
			rowMode <= next_rowMode;
			highVolt <= next_highVolt;
			wpMeta <= wpPinN;
			wpSync <= wpMeta;
		end
	end

	assign hreadyout = !(aValid && aIsData) || ioAck;
	assign hresp = fprc_pkg::HRESP_OKAY;
	assign hrdata = hrdataReg;
	assign memRdata = memRdataReg;
	assign memDone = memDoneReg;
	assign arrRdEn = (rdState == fprc_pkg::RD_WAIT);
	assign arrRdAddr = rdAddr;
	assign arrRdInfo = rdInfo;
	assign arrPgStrobe = (pgState == fprc_pkg::PG_BYTE);
	assign arrPgAddr = pgAddr;
	assign arrPgInfo = pgInfo;
	assign arrPgData = pgData;
	assign arrHighVolt = highVolt;

endmodule

`default_nettype wire

// File: verification/fprc_array_model.sv
// Behavioural array: main pages plus information page, erased to all ones.
// Assumes read data is sampled by the controller on the core clock.
`timescale 1ns/10ps
`default_nettype none

module fprc_array_model (
	input wire logic clk, // core clock
	input wire logic rdEn, // read enable
	input wire logic [17:0] rdAddr, // read address
	input wire logic rdInfo, // read info page
	output logic [7:0] rdData, // read data
	input wire logic pgStrobe, // programming
	input wire logic [17:0] pgAddr, // program address
	input wire logic pgInfo, // program info page
	input wire logic [7:0] pgData // program data
);
	logic [7:0] mem [int];
	logic [7:0] cur;
	always_comb begin
		cur = mem.exists({rdInfo, rdAddr}) ? mem[{rdInfo, rdAddr}] : 8'hff;
		// An idle read port shows junk so stale data cannot pass.
		rdData = rdEn ? cur : ~cur;
	end
	always @(posedge clk) begin
		if (pgStrobe) begin
			mem[{pgInfo, pgAddr}] = pgData;
		end
	end
endmodule

`default_nettype wire

// File: verification/fprc_tb_top.sv
// Self-checking bench: bus and memory-port stimulus against a byte model.
// Assumes shortened programming counts so a row time-out fits the run.
`timescale 1ns/10ps
`default_nettype none

module fprc_tb_top;
	logic core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic memReq = 1'b0, memWrite = 1'b0, wpPinN = 1'b1, hv;
	logic [17:0] memAddr = 18'h0, arrRdAddr, arrPgAddr;
	logic [7:0] memWdata = 8'h0, memRdata, arrRdData, arrPgData, d, q;
	logic hreadyout, hresp, memDone, arrRdEn, arrRdInfo, arrPgStrobe;
	logic arrPgInfo, arrHighVolt;
	logic [7:0] mdl [int];
	int fails = 0, checked = 0, seed = 15394, pg, rw, cl, k, i;
	always #5 core_clk = ~core_clk;
	fprc_top #(.BYTE_PROG_CYCLES(20), .ROW_BYTE_PROG_CYCLES(12),
		.ROW_LIMIT_CYCLES(2000)) uut (.core_clk, .rst, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
		.hresp, .hrdata, .memReq, .memWrite, .memAddr, .memWdata,
		.memRdata, .memDone, .wpPinN, .arrRdEn, .arrRdAddr, .arrRdInfo,
		.arrRdData, .arrPgStrobe, .arrPgAddr, .arrPgInfo, .arrPgData,
		.arrHighVolt);
	fprc_array_model u_arr (.clk(core_clk), .rdEn(arrRdEn),
		.rdAddr(arrRdAddr), .rdInfo(arrRdInfo), .rdData(arrRdData),
		.pgStrobe(arrPgStrobe), .pgAddr(arrPgAddr), .pgInfo(arrPgInfo),
		.pgData(arrPgData));
	task automatic end_of_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [7:0] e, g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask
	function automatic logic [7:0] get(input int a);
		return mdl.exists(a) ? mdl[a] : 8'hff;
	endfunction
	function automatic int key();
		return (pg / 128) * 262144 + (pg % 128) * 2048 + rw * 256 + cl;
	endfunction
	// A wait ends on the edge where the answer is sampled high.
	task automatic wrdy(input logic s, output logic [7:0] r);
		int n = 0;
		logic ok;
		while (ok !== 1'b1) begin
			@(negedge core_clk);
			ok = s ? memDone : hreadyout;
			r = s ? memRdata : hrdata[7:0];
			hv = arrHighVolt;
			@(posedge core_clk);
			n++;
			if (n > 5000) begin
				fails++;
				end_of_test();
			end
		end
	endtask
	task automatic ahb(input logic w, input logic [9:0] x,
		input logic [7:0] v, output logic [7:0] r);
		hsel <= 1'b1;
		htrans <= fprc_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {20'h0, x, 2'h0};
		wrdy(1'b0, r);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, v};
		wrdy(1'b0, r);
	endtask
	task automatic mcy(input logic w, input int a, input logic [7:0] v);
		memReq <= 1'b1;
		memWrite <= w;
		memAddr <= a[17:0];
		memWdata <= v;
		wrdy(1'b1, q);
		memReq <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic setadr(input int p, r, c);
		ahb(1'b1, fprc_pkg::IDX_PAGE, p[7:0], q);
		ahb(1'b1, fprc_pkg::IDX_ROW, r[7:0], q);
		ahb(1'b1, fprc_pkg::IDX_COL, c[7:0], q);
		pg = p;
		rw = r;
		cl = c;
	endtask
	task automatic adv(input logic w);
		if (w) begin
			mdl[key()] = d;
		end else begin
			chk("data", get(key()), q);
		end
		cl = (cl + 1) % 256;
		rw = cl == 0 ? (rw + 1) % 8 : rw;
		pg = cl == 0 && rw == 0 ? (pg & 128) | ((pg + 1) & 127) : pg;
	endtask
	task automatic dat(input logic w);
		d = $random(seed);
		ahb(w, fprc_pkg::IDX_DATA, d, q);
		adv(w);
	endtask
	task automatic chkadr();
		int e [3] = '{pg, rw, cl};
		for (int j = 0; j < 3; j++) begin
			ahb(1'b0, fprc_pkg::IDX_PAGE + 10'(j), 8'h0, q);
			chk("address", e[j][7:0], q);
		end
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		ahb(1'b1, fprc_pkg::IDX_CTRL, 8'h0a, q);
		ahb(1'b0, fprc_pkg::IDX_CTRL, 8'h0, q);
		chk("ctrl", 8'h0a, q);
		ahb(1'b0, 10'h3ff, 8'h0, q);
		chk("unmapped", 8'h00, q);
		setadr(5, 7, 255);
		k = key();
		dat(1'b1);
		chkadr();
		mcy(1'b0, k, 8'h0);
		chk("memrd", get(k), q);
		k = 9 * 2048 + 3 * 256 + 16;
		d = $random(seed);
		mcy(1'b1, k, d);
		mdl[k] = d;
		setadr(9, 3, 16);
		dat(1'b0);
		dat(1'b0);
		wpPinN <= 1'b0;
		repeat (3) @(posedge core_clk);
		mcy(1'b1, 16, 8'h00);
		mcy(1'b0, 16, 8'h0);
		chk("boot", 8'hff, q);
		ahb(1'b0, fprc_pkg::IDX_STAT, 8'h0, q);
		chk("protflag", 8'h04, q & 8'h04);
		ahb(1'b1, fprc_pkg::IDX_STAT, 8'h04, q);
		wpPinN <= 1'b1;
		ahb(1'b0, fprc_pkg::IDX_STAT, 8'h0, q);
		chk("protclr", 8'h00, q & 8'h04);
		mcy(1'b1, 32, 8'h5a);
		setadr(133, 1, 7);
		dat(1'b1);
		setadr(133, 1, 7);
		dat(1'b0);
		mcy(1'b0, 5 * 2048 + 256 + 7, 8'h0);
		chk("nomeminfo", 8'hff, q);
		setadr(2, 0, 253);
		ahb(1'b1, fprc_pkg::IDX_PGCTL, 8'h01, q);
		for (i = 0; i < 3; i++) begin
			dat(1'b1);
			chk("rowhv", {7'h0, i < 2}, {7'h0, hv});
		end
		ahb(1'b0, fprc_pkg::IDX_STAT, 8'h0, q);
		chk("rowdone", 8'h01, q & 8'h01);
		chkadr();
		setadr(2, 0, 253);
		for (i = 0; i < 3; i++) begin
			dat(1'b0);
		end
		setadr(3, 0, 0);
		ahb(1'b1, fprc_pkg::IDX_PGCTL, 8'h01, q);
		dat(1'b1);
		repeat (2020) @(posedge core_clk);
		ahb(1'b0, fprc_pkg::IDX_STAT, 8'h0, q);
		chk("timeout", 8'h02, q & 8'h02);
		chk("abort", 8'h00, {7'h0, hv});
		end_of_test();
	end
endmodule

`default_nettype wire

// File: verification/fprc_top_props.sv
// Concurrent checks on the ports of the flash read and program controller.
// Assumes one core clock domain and the asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module fprc_top_props (
	input wire logic core_clk, // core clock
	input wire logic rst, // reset
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write transfer
	input wire logic hready, // bus ready
	input wire logic hreadyout, // slave ready
	input wire logic hresp, // response
	input wire logic memReq, // memory cycle
	input wire logic memWrite, // memory write
	input wire logic memDone, // memory done
	input wire logic wpPinN, // write-protect pin
	input wire logic arrRdEn, // array read
	input wire logic [fprc_pkg::ADDR_W-1:0] arrRdAddr, // read address
	input wire logic arrPgStrobe, // programming
	input wire logic [fprc_pkg::ADDR_W-1:0] arrPgAddr, // program address
	input wire logic arrPgInfo, // info page
	input wire logic [7:0] arrPgData, // program data
	input wire logic arrHighVolt // high voltage
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence s_dataRd;
		hsel && hready && !hwrite &&
			htrans == fprc_pkg::HTRANS_NONSEQ &&
			haddr[11:2] == fprc_pkg::IDX_DATA;
	endsequence
	sequence s_pgStart;
		$rose(arrPgStrobe);
	endsequence
	property p_pgLen;
		s_pgStart |-> arrPgStrobe [*8];
	endproperty
	property p_hvStart;
		$rose(arrHighVolt) |-> arrPgStrobe;
	endproperty
	property p_hvPg;
		arrPgStrobe |-> arrHighVolt;
	endproperty
	property p_pgHold;
		arrPgStrobe && $past(arrPgStrobe) |->
			$stable(arrPgAddr) && $stable(arrPgData);
	endproperty
	property p_rdHold;
		arrRdEn && $past(arrRdEn) |-> $stable(arrRdAddr);
	endproperty
	property p_dataWait;
		s_dataRd |=> !hreadyout ##1 !hreadyout;
	endproperty
	property p_memDone;
		memDone |-> memReq ##1 !memDone;
	endproperty
	property p_memWr;
		memDone && memWrite |-> !arrHighVolt;
	endproperty
	property p_boot;
		arrPgStrobe && !arrPgInfo && arrPgAddr[17:15] == 3'h0 |->
			$past(wpPinN, 3);
	endproperty
	property p_okay;
		hresp == fprc_pkg::HRESP_OKAY;
	endproperty
	a_pgLen: assert property (p_pgLen)
		else $error("short program pulse");
	a_hvStart: assert property (p_hvStart)
		else $error("stray high voltage");
	a_hvPg: assert property (p_hvPg)
		else $error("program without voltage");
	a_pgHold: assert property (p_pgHold)
		else $error("program inputs moved");
	a_rdHold: assert property (p_rdHold)
		else $error("read address moved");
	a_dataWait: assert property (p_dataWait)
		else $error("read without wait states");
	a_memDone: assert property (p_memDone)
		else $error("memory done malformed");
	a_memWr: assert property (p_memWr)
		else $error("voltage left on");
	a_boot: assert property (p_boot)
		else $error("boot block programmed");
	a_okay: assert property (p_okay)
		else $error("response not okay");
endmodule

bind fprc_top fprc_top_props u_props (.core_clk, .rst, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hreadyout, .hresp, .memReq, .memWrite,
	.memDone, .wpPinN, .arrRdEn, .arrRdAddr, .arrPgStrobe, .arrPgAddr,
	.arrPgInfo, .arrPgData, .arrHighVolt);

`default_nettype wire
